/* pkg/dmc_defines.vh */
// Purpose: constants for the dma descriptor pointer / channel mode block
// Assumes: 32-bit register port, byte addresses as printed
// Notes: included by rtl/dmc_top.v and rtl/dmc_fifo.v
// Function
// - pointer bit 0: descriptors in pci space
// - pointer bit 1: last descriptor in chain
// - pointer bit 2: interrupt at terminal count
// - pointer bit 3: 1 local-to-pci, 0 reverse
// - next descriptor address, low nibble zero
// - width 00 8-bit, 01 16-bit, else 32
// - mode bit 6 enables ready input, reset 1
// - mode bit 7 enables burst-terminate input
// - mode bit 8 allows local bursts
// - mode bit 9 scatter/gather, else block mode
// - done interrupt; waits for count clear
// - mode bit 11 holds local address constant
// - demand mode: move only on request, ack
// - demand words split on narrow buses
// - invalidate writes when line size 8/16
// - otherwise ordinary memory writes
// - mode bit 14 enables end-of-transfer input
// - slow terminate: burst-last or boundary stop
// - fast terminate: stop at once, no burst_in_progress_out
// - clear-count writes zero byte count, scatter/gather mode only
`ifndef DMC_DEFINES_VH
`define DMC_DEFINES_VH
// -----------------------------------------------------------
// register offsets and resets
// -----------------------------------------------------------
`define DMC_OFS_DPTR 8'h90
`define DMC_OFS_MODE 8'h94
`define DMC_DPTR_RST 32'h00000000
`define DMC_MODE_RST 32'h00000043
// -----------------------------------------------------------
// field positions
// -----------------------------------------------------------
`define DMC_DP_PCI 0
`define DMC_DP_EOC 1
`define DMC_DP_TCI 2
`define DMC_DP_DIR 3
`define DMC_MD_RDY 6
`define DMC_MD_BURST_TERMINATE_INPUT 7
`define DMC_MD_BURST 8
`define DMC_MD_SG 9
`define DMC_MD_DONE 10
`define DMC_MD_HOLD 11
`define DMC_MD_DEMAND 12
`define DMC_MD_MWI 13
`define DMC_MD_EOT 14
`define DMC_MD_FAST 15
`define DMC_MD_CLRCNT 16
`define DMC_MODE_MASK 32'h0001FFFF
`define DMC_DPTR_MASK 32'hFFFFFFFF
// -----------------------------------------------------------
// codes and sizes
// -----------------------------------------------------------
`define DMC_CLS_8 8'h08
`define DMC_CLS_16 8'h10
`define DMC_BOUNDARY_BYTES 5'h10
`define DMC_FIFO_DEPTH 16
`endif

/* rtl/dmc_fifo.v */
// Purpose: word fifo between pci side and local side of the channel
// Assumes: one clock, synchronous active-low reset
// Notes: depth must be a power of two
`timescale 1ns/1ps
`include "dmc_defines.vh"
module dmc_fifo #(
   parameter WIDTH = 32,
   parameter DEPTH = `DMC_FIFO_DEPTH,
   parameter AW = 4
)(
   // clock and reset
   input wire clk_i,
   input wire nrst_i,
   // fill side
   input wire in_valid_i,
   output wire in_ready_o,
   input wire [WIDTH-1:0] in_data_i,
   // drain side
   output wire out_valid_o,
   input wire out_ready_i,
   output wire [WIDTH-1:0] out_data_o
);
   reg [WIDTH-1:0] mem [0:DEPTH-1]; // flip-flop storage
   reg [AW:0] wr_ptr; // extra bit tells full from empty
   reg [AW:0] rd_ptr;
   wire full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
   wire empty = (wr_ptr == rd_ptr);
   wire push = in_valid_i && !full;
   wire pop = out_ready_i && !empty;
   assign in_ready_o = !full;
   assign out_valid_o = !empty;
   assign out_data_o = mem[rd_ptr[AW-1:0]];
   // pointer update
   always @(posedge clk_i)
   begin
      if (!nrst_i)
      begin
         wr_ptr <= {(AW+1){1'b0}};
         rd_ptr <= {(AW+1){1'b0}};
      end
      else
      begin
         if (push)
            wr_ptr <= wr_ptr + 1'b1;
         if (pop)
            rd_ptr <= rd_ptr + 1'b1;
      end
   end
   // storage write, no reset needed for data
   always @(posedge clk_i)
   begin
      if (push)
         mem[wr_ptr[AW-1:0]] <= in_data_i;
   end
endmodule // dmc_fifo

/* rtl/dmc_top.v */
// Purpose: descriptor pointer, channel mode word and the local-side mover they steer
// Assumes: registers reached on a simple 32-bit register port; one clock
// Notes: pci side pushes words into the fifo; local side drains in lanes
`timescale 1ns/1ps
`include "dmc_defines.vh"
module dmc_top #(
   parameter CNT_W = 23
)(
   // clock and reset
   input wire clk_i,
   input wire nrst_i,
   // register port
   input wire reg_wr_i,
   input wire reg_rd_i,
   input wire [7:0] reg_addr_i,
   input wire [31:0] reg_wdata_i,
   output reg [31:0] reg_rdata_o,
   // channel control
   input wire start_i,
   input wire [CNT_W-1:0] byte_count_i,
   input wire [31:0] local_addr_i,
   input wire [7:0] cache_line_size_setting_i,
   input wire [1:0] personality_i,
   // pci side word stream
   input wire pci_valid_i,
   output reg pci_ready_o,
   input wire [31:0] pci_data_i,
   // local pins
   input wire local_ready_input_i,
   input wire burst_terminate_input_i,
   input wire chan1_transfer_request_i,
   input wire end_of_transfer_input_i,
   output reg chan1_transfer_ack_o,
   output reg burst_last_strobe_o,
   output reg burst_in_progress_out_o,
   output reg local_strobe_o,
   output reg [31:0] local_addr_o,
   output reg [7:0] local_data_o,
   output reg [1:0] local_lane_o,
   // status
   output reg busy_o,
   output reg done_irq_o,
   output reg tc_irq_o,
   output reg clear_count_o,
   output reg use_mwi_o,
   output reg [1:0] bus_bytes_o,
   output reg [27:0] next_desc_o,
   output reg desc_in_pci_o,
   output reg last_desc_o,
   output reg dir_to_pci_o
);
   // -----------------------------------------------------------
   // registers
   // -----------------------------------------------------------
   reg [31:0] dptr; // descriptor pointer
   reg [31:0] mode; // channel mode
   reg [2:0] rdy_s; // ready pin synchroniser
   reg [2:0] bt_s; // burst-terminate synchroniser
   reg [2:0] req_s; // request synchroniser
   reg [2:0] eot_s; // end-of-transfer synchroniser
   reg rdy_f, bt_f, req_f, eot_f; // filtered pin levels
   // register writes and reads
   always @(posedge clk_i)
   begin
      if (!nrst_i)
      begin
         dptr <= `DMC_DPTR_RST;
         mode <= `DMC_MODE_RST;
      end
      else if (reg_wr_i)
      begin
         if (reg_addr_i == `DMC_OFS_DPTR)
            dptr <= {reg_wdata_i[31:4], reg_wdata_i[3:0]};
         else if (reg_addr_i == `DMC_OFS_MODE)
            mode <= reg_wdata_i & `DMC_MODE_MASK;
      end
   end
   // read mux; unmapped reads zero
   always @(posedge clk_i)
   begin
      if (!nrst_i)
         reg_rdata_o <= 32'h00000000;
      else if (reg_rd_i && reg_addr_i == `DMC_OFS_DPTR)
         reg_rdata_o <= dptr;
      else if (reg_rd_i && reg_addr_i == `DMC_OFS_MODE)
         reg_rdata_o <= mode;
      else
         reg_rdata_o <= 32'h00000000;
   end
   // -----------------------------------------------------------
   // pin synchronisers: change accepted when stages 2 and 3 agree
   // -----------------------------------------------------------
   always @(posedge clk_i)
   begin
      if (!nrst_i)
      begin
         rdy_s <= 3'h7;
         bt_s <= 3'h7;
         req_s <= 3'h7;
         eot_s <= 3'h7;
         rdy_f <= 1'b1;
         bt_f <= 1'b1;
         req_f <= 1'b1;
         eot_f <= 1'b1;
      end
      else
      begin
         rdy_s <= {rdy_s[1:0], local_ready_input_i};
         bt_s <= {bt_s[1:0], burst_terminate_input_i};
         req_s <= {req_s[1:0], chan1_transfer_request_i};
         eot_s <= {eot_s[1:0], end_of_transfer_input_i};
         if (rdy_s[1] == rdy_s[2])
            rdy_f <= rdy_s[2];
         if (bt_s[1] == bt_s[2])
            bt_f <= bt_s[2];
         if (req_s[1] == req_s[2])
            req_f <= req_s[2];
         if (eot_s[1] == eot_s[2])
            eot_f <= eot_s[2];
      end
   end
   // -----------------------------------------------------------
   // decoded mode (pins are active low)
   // -----------------------------------------------------------
   wire [1:0] width_code = mode[1:0];
   wire [1:0] nbytes_m1 = (width_code == 2'h0) ? 2'h0 :
      (width_code == 2'h1) ? 2'h1 : 2'h3;
   // beats per fifo word, minus one: a narrow bus needs several beats per word
   wire [1:0] beats_m1 = (width_code == 2'h0) ? 2'h3 :
      (width_code == 2'h1) ? 2'h1 : 2'h0;
   wire rdy_ok = !mode[`DMC_MD_RDY] || !rdy_f;
   wire burst_terminate_input = mode[`DMC_MD_BURST_TERMINATE_INPUT] && !bt_f;
   wire demand = mode[`DMC_MD_DEMAND];
   wire req_on = !demand || !req_f;
   wire eot = mode[`DMC_MD_EOT] && !eot_f;
   wire fast = mode[`DMC_MD_FAST];
   wire native = (personality_i == 2'h2); // processor-native personality
   wire cls_ok = (cache_line_size_setting_i == `DMC_CLS_8) ||
      (cache_line_size_setting_i == `DMC_CLS_16);
   // -----------------------------------------------------------
   // fifo between pci side and local side
   // -----------------------------------------------------------
   wire f_in_ready;
   wire f_out_valid;
   wire [31:0] f_out_data;
   reg f_pop;
   dmc_fifo #(.WIDTH(32), .DEPTH(`DMC_FIFO_DEPTH), .AW(4)) u_fifo (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .in_valid_i(pci_valid_i && pci_ready_o),
      .in_ready_o(f_in_ready),
      .in_data_i(pci_data_i),
      .out_valid_o(f_out_valid),
      .out_ready_i(f_pop),
      .out_data_o(f_out_data)
   );
   // -----------------------------------------------------------
   // local mover state machine
   // -----------------------------------------------------------
   localparam ST_IDLE = 2'h0;
   localparam ST_XFER = 2'h1;
   localparam ST_STOP = 2'h2;
   localparam ST_DONE = 2'h3; // done pulse held back for the count clear
   reg [1:0] state;
   reg [1:0] lane; // byte lane within current word
   reg [CNT_W-1:0] remain; // bytes left
   wire beat = (state == ST_XFER) && f_out_valid && req_on && rdy_ok;
   reg [31:0] cur_addr; // address of the next beat; the pins show the current one
   wire word_end = (lane == beats_m1);
   // byte of the word carried on the low lane in this beat
   wire [1:0] byte_ofs = (width_code == 2'h0) ? lane :
      (width_code == 2'h1) ? {lane[0], 1'b0} : 2'h0;
   wire last_beat = beat && word_end && (remain <= 23'h000004);
   wire [31:0] addr_step = {29'h00000000, nbytes_m1 + 3'h1};
   wire at_boundary = (cur_addr[3:0] + {2'h0, nbytes_m1}) == 4'hF;
   // fifo pop when a whole word has gone out
   always @*
   begin
      f_pop = beat && word_end;
   end
   // sequencing and pin drive
   always @(posedge clk_i)
   begin
      if (!nrst_i)
      begin
         state <= ST_IDLE;
         lane <= 2'h0;
         remain <= {CNT_W{1'b0}};
         busy_o <= 1'b0;
         local_strobe_o <= 1'b0;
         local_addr_o <= 32'h00000000;
         cur_addr <= 32'h00000000;
         local_data_o <= 8'h00;
         local_lane_o <= 2'h0;
         chan1_transfer_ack_o <= 1'b1;
         burst_last_strobe_o <= 1'b1;
         burst_in_progress_out_o <= 1'b1;
         done_irq_o <= 1'b0;
         tc_irq_o <= 1'b0;
         clear_count_o <= 1'b0;
      end
      else
      begin
         local_strobe_o <= 1'b0;
         chan1_transfer_ack_o <= 1'b1;
         burst_last_strobe_o <= 1'b1;
         done_irq_o <= 1'b0;
         tc_irq_o <= 1'b0;
         clear_count_o <= 1'b0;
         case (state)
            ST_IDLE:
            begin
               burst_in_progress_out_o <= 1'b1;
               if (start_i)
               begin
                  state <= ST_XFER;
                  busy_o <= 1'b1;
                  remain <= byte_count_i;
                  lane <= 2'h0;
                  cur_addr <= local_addr_i;
               end
            end
            ST_XFER:
            begin
               // fast terminate: stop at once on end-of-transfer
               if (eot && fast)
                  state <= ST_STOP;
               else if ((eot || burst_terminate_input) && !fast && native && at_boundary)
                  state <= ST_STOP;
               else if (beat)
               begin
                  local_strobe_o <= 1'b1;
                  local_lane_o <= lane;
                  local_data_o <= f_out_data[8*byte_ofs +: 8];
                  local_addr_o <= cur_addr;
                  chan1_transfer_ack_o <= !demand;
                  // bursting held off unless enabled with fast terminate off; single beats otherwise
                  burst_in_progress_out_o <= !(mode[`DMC_MD_BURST] && !fast);
                  if (!mode[`DMC_MD_HOLD])
                     cur_addr <= cur_addr + addr_step;
                  lane <= word_end ? 2'h0 : lane + 2'h1;
                  if (word_end)
                     remain <= (remain > 23'h000004) ? remain - 23'h000004 : {CNT_W{1'b0}};
                  // burst-last, outside native personality, on final beat, on every beat when bursts are off, or slow-terminate request
                  if (last_beat || !mode[`DMC_MD_BURST] || (!fast && (eot || burst_terminate_input)))
                     burst_last_strobe_o <= native;
                  if (last_beat || (!fast && !native && (eot || burst_terminate_input)))
                     state <= ST_STOP;
               end
            end
            ST_STOP:
            begin
               state <= ST_IDLE;
               busy_o <= 1'b0;
               burst_in_progress_out_o <= 1'b1;
               clear_count_o <= mode[`DMC_MD_CLRCNT] && mode[`DMC_MD_SG];
               tc_irq_o <= dptr[`DMC_DP_TCI];
               // with clear-count in scatter/gather mode the done interrupt waits one cycle for the clear
               if (!(mode[`DMC_MD_CLRCNT] && mode[`DMC_MD_SG]))
                  done_irq_o <= mode[`DMC_MD_DONE];
               else
                  state <= ST_DONE;
            end
            ST_DONE:
            begin
               state <= ST_IDLE;
               done_irq_o <= mode[`DMC_MD_DONE];
            end
            default:
               state <= ST_IDLE;
         endcase
      end
   end
   // -----------------------------------------------------------
   // registered decode outputs
   // -----------------------------------------------------------
   always @(posedge clk_i)
   begin
      if (!nrst_i)
      begin
         pci_ready_o <= 1'b0;
         use_mwi_o <= 1'b0;
         bus_bytes_o <= 2'h0;
         next_desc_o <= 28'h0000000;
         desc_in_pci_o <= 1'b0;
         last_desc_o <= 1'b0;
         dir_to_pci_o <= 1'b0;
      end
      else
      begin
         // back-pressure from the local side reaches the pci source; being registered,
         // ready is offered every other cycle so the full flag catches up with each push
         pci_ready_o <= f_in_ready && busy_o && !pci_ready_o;
         use_mwi_o <= mode[`DMC_MD_MWI] && cls_ok;
         bus_bytes_o <= nbytes_m1;
         next_desc_o <= dptr[31:4];
         desc_in_pci_o <= dptr[`DMC_DP_PCI];
         last_desc_o <= dptr[`DMC_DP_EOC] || !mode[`DMC_MD_SG];
         dir_to_pci_o <= dptr[`DMC_DP_DIR];
      end
   end
endmodule // dmc_top

/* verification/dmc_far_model.sv */
// Purpose: local-bus far side of dmc_top: ready, request, terminate pins
// Assumes: every pin active low, changed just after a clock edge
// Notes: ready may be withheld or slowed to stress the ready enable
`timescale 1ns/1ps
module dmc_far_model (
   // clock
   input wire clk_i,
   // bench controls
   input wire ready_on_i,
   input wire slow_i,
   input wire request_on_i,
   input wire eot_on_i,
   // pins toward the channel
   output reg ready_n_o = 1'b1,
   output reg request_n_o = 1'b1,
   output reg burst_terminate_input_n_o = 1'b1,
   output reg eot_n_o = 1'b1
);
   reg [1:0] phase = 2'h0; // slow responder holds each level two cycles, so the filter passes it
   // -----------------------------------------------------------
   // pin drive
   // -----------------------------------------------------------
   always @(posedge clk_i)
   begin
      phase <= phase + 2'h1;
      ready_n_o <= !(ready_on_i && (!slow_i || phase[1]));
      request_n_o <= !request_on_i;
      burst_terminate_input_n_o <= 1'b1; // bursts are never cut short here
      eot_n_o <= !eot_on_i;
   end
endmodule // dmc_far_model

/* verification/dmc_top_sva.sv */
// Purpose: port-level checks of dmc_top
// Assumes: one clock, synchronous active-low reset
// Notes: bound into every dmc_top instance
`timescale 1ns/1ps
module dmc_top_sva #(
   parameter CNT_W = 23
)(
   // clock and reset
   input wire clk_i,
   input wire nrst_i,
   // register port
   input wire reg_wr_i,
   input wire reg_rd_i,
   input wire [7:0] reg_addr_i,
   input wire [31:0] reg_wdata_i,
   input wire [31:0] reg_rdata_o,
   // levels and pins
   input wire [7:0] cache_line_size_setting_i,
   input wire [1:0] personality_i,
   input wire chan1_transfer_ack_o,
   input wire burst_last_strobe_o,
   input wire local_strobe_o,
   input wire [1:0] local_lane_o,
   // status
   input wire busy_o,
   input wire done_irq_o,
   input wire tc_irq_o,
   input wire clear_count_o,
   input wire use_mwi_o,
   input wire [1:0] bus_bytes_o,
   input wire [27:0] next_desc_o,
   input wire desc_in_pci_o,
   input wire last_desc_o,
   input wire dir_to_pci_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   // -----------------------------------------------------------
   // assertions
   // -----------------------------------------------------------
   property p_ptr;
      reg_wr_i && reg_addr_i == 8'h90 |-> ##2 next_desc_o == $past(reg_wdata_i[31:4], 2)
         && dir_to_pci_o == $past(reg_wdata_i[3], 2) && desc_in_pci_o == $past(reg_wdata_i[0], 2)
         && (last_desc_o || !$past(reg_wdata_i[1], 2));
   endproperty
   a_ptr: assert property (p_ptr) else $error("pointer decode wrong");
   property p_width;
      reg_wr_i && reg_addr_i == 8'h94 |-> ##2
         bus_bytes_o == ($past(reg_wdata_i[1], 2) ? 2'h3 : {1'b0, $past(reg_wdata_i[0], 2)});
   endproperty
   a_width: assert property (p_width) else $error("bus width decode wrong");
   property p_mode_hi;
      reg_rd_i && reg_addr_i == 8'h94 |=> reg_rdata_o[31:17] == 15'h0000;
   endproperty
   a_mode_hi: assert property (p_mode_hi) else $error("mode high bits set");
   property p_mwi;
      use_mwi_o |-> $past(cache_line_size_setting_i) inside {8'h08, 8'h10};
   endproperty
   a_mwi: assert property (p_mwi) else $error("invalidate with bad line size");
   property p_lane;
      local_strobe_o |-> busy_o && (bus_bytes_o == 2'h0
         || local_lane_o <= (bus_bytes_o == 2'h1 ? 2'h1 : 2'h0));
   endproperty
   a_lane: assert property (p_lane) else $error("lane beyond bus width");
   property p_ack;
      !chan1_transfer_ack_o |-> busy_o || $past(busy_o);
   endproperty
   a_ack: assert property (p_ack) else $error("ack while idle");
   property p_tc;
      tc_irq_o |-> !busy_o ##1 !tc_irq_o;
   endproperty
   a_tc: assert property (p_tc) else $error("count interrupt misplaced");
   property p_clr;
      clear_count_o |-> !done_irq_o ##1 !clear_count_o;
   endproperty
   a_clr: assert property (p_clr) else $error("done before count cleared");
   property p_burst_last_strobe;
      !burst_last_strobe_o |-> personality_i != 2'h2;
   endproperty
   a_burst_last_strobe: assert property (p_burst_last_strobe) else $error("burst-last in native");
endmodule // dmc_top_sva
bind dmc_top dmc_top_sva #(.CNT_W(CNT_W)) i_dmc_top_sva (.clk_i(clk_i), .nrst_i(nrst_i),
   .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
   .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
   .cache_line_size_setting_i(cache_line_size_setting_i), .personality_i(personality_i),
   .chan1_transfer_ack_o(chan1_transfer_ack_o), .burst_last_strobe_o(burst_last_strobe_o),
   .local_strobe_o(local_strobe_o), .local_lane_o(local_lane_o), .busy_o(busy_o),
   .done_irq_o(done_irq_o), .tc_irq_o(tc_irq_o), .clear_count_o(clear_count_o),
   .use_mwi_o(use_mwi_o), .bus_bytes_o(bus_bytes_o), .next_desc_o(next_desc_o),
   .desc_in_pci_o(desc_in_pci_o), .last_desc_o(last_desc_o), .dir_to_pci_o(dir_to_pci_o));

/* verification/dmc_top_tb_top.sv */
// Purpose: register and transfer tests of dmc_top
// Assumes: 40 MHz clock, inputs changed by non-blocking writes at edges
// Notes: counts are 8 bytes, line aligned at local address 0x100
`timescale 1ns/1ps
module dmc_top_tb_top;
   // design inputs
   reg clk_i = 1'b0;
   reg nrst_i = 1'b0;
   reg reg_wr_i = 1'b0;
   reg reg_rd_i = 1'b0;
   reg [7:0] reg_addr_i = 8'h00;
   reg [31:0] reg_wdata_i = 32'h00000000;
   reg start_i = 1'b0;
   reg [22:0] byte_count_i = 23'h000008;
   reg [31:0] local_addr_i = 32'h00000100;
   reg [7:0] cache_line_size_setting_i = 8'h08;
   reg [1:0] personality_i = 2'h0;
   reg pci_valid_i = 1'b1;
   reg [31:0] pci_data_i = 32'h44332211;
   reg rdy_on = 1'b1;
   reg slow_on = 1'b0;
   reg req_on = 1'b1;
   // design outputs and pins
   wire [31:0] reg_rdata_o, local_addr_o;
   wire [27:0] next_desc_o;
   wire [7:0] local_data_o;
   wire [1:0] local_lane_o, bus_bytes_o;
   wire pci_ready_o, chan1_transfer_ack_o, burst_last_strobe_o, burst_in_progress_out_o;
   wire local_strobe_o, busy_o, done_irq_o, tc_irq_o, clear_count_o, use_mwi_o;
   wire desc_in_pci_o, last_desc_o, dir_to_pci_o;
   wire local_ready_input_i, burst_terminate_input_i;
   wire chan1_transfer_request_i, end_of_transfer_input_i;
   integer failures = 0;
   integer num_checks = 0;
   integer i;
   reg [31:0] v;
   reg quiet;
   reg ack_exp = 1'b1; // ack level expected with each strobe
   reg eot_on = 1'b0;
   dmc_top #(.CNT_W(23)) i_dmc_top (.*);
   dmc_far_model i_dmc_far_model (.clk_i(clk_i), .ready_on_i(rdy_on), .slow_i(slow_on),
      .request_on_i(req_on), .eot_on_i(eot_on), .ready_n_o(local_ready_input_i),
      .request_n_o(chan1_transfer_request_i), .burst_terminate_input_n_o(burst_terminate_input_i),
      .eot_n_o(end_of_transfer_input_i));
   always #12.5 clk_i = !clk_i;
   // -----------------------------------------------------------
   // tasks
   // -----------------------------------------------------------
   task test_done;
   begin
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   end
   endtask
   task chk(input [31:0] seen, input [31:0] exp, input [8*8-1:0] what);
   begin
      num_checks = num_checks + 1;
      if (seen !== exp)
      begin
         failures = failures + 1;
         $display("wrong value %0s exp %h seen %h", what, exp, seen);
      end
   end
   endtask
   task wr(input [7:0] a, input [31:0] d);
   begin
      @(posedge clk_i);
      reg_wr_i <= 1'b1;
      reg_addr_i <= a;
      reg_wdata_i <= d;
      @(posedge clk_i);
      reg_wr_i <= 1'b0;
   end
   endtask
   // read data is registered, so it is looked at just after the next edge
   task rd(input [7:0] a, input [31:0] exp);
   begin
      @(posedge clk_i);
      reg_rd_i <= 1'b1;
      reg_addr_i <= a;
      @(posedge clk_i);
      reg_rd_i <= 1'b0;
      #1 chk(reg_rdata_o, exp, "rdata");
   end
   endtask
   task start_x(input [31:0] mode, input [31:0] ptr);
   begin
      wr(8'h94, mode);
      wr(8'h90, ptr);
      @(posedge clk_i);
      start_i <= 1'b1;
      @(posedge clk_i);
      start_i <= 1'b0;
   end
   endtask
   // follows one transfer until busy has been low for three cycles
   task watch(input [31:0] beats, input [31:0] step, input [2:0] flags);
      integer n, k, idle;
      reg [31:0] prev;
      reg [2:0] seen;
   begin
      n = 0;
      k = 0;
      idle = 0;
      seen = 3'h0;
      prev = 32'h0;
      while (k < 400 && idle < 3)
      begin
         @(posedge clk_i);
         #1 k = k + 1;
         idle = busy_o ? 0 : idle + 1;
         seen = seen | {clear_count_o, done_irq_o, tc_irq_o};
         if (local_strobe_o)
         begin
            if (n > 0)
               chk(local_addr_o, prev + step, "addr");
            else
               chk(local_addr_o, local_addr_i, "addr");
            chk(chan1_transfer_ack_o, ack_exp, "ack");
            if (bus_bytes_o == 2'h0)
               chk(local_data_o, pci_data_i[8*(n%4) +: 8], "byte");
            prev = local_addr_o;
            n = n + 1;
         end
      end
      if (k == 400)
      begin
         failures = failures + 1;
         test_done;
      end
      chk(n, beats, "beats");
      chk({pci_ready_o, burst_in_progress_out_o}, 2'h1, "idle");
      chk(seen, flags, "events");
   end
   endtask
   // -----------------------------------------------------------
   // tests
   // -----------------------------------------------------------
   initial
   begin
      repeat (6) @(posedge clk_i);
      nrst_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      rd(8'h90, 32'h0);
      rd(8'h94, 32'h43);
      rd(8'h98, 32'h0);
      $display("test reset done");
      wr(8'h94, 32'h243);
      for (i = 0; i < 2; i = i + 1)
      begin
         v = i ? 32'h5A5A5A54 : 32'hA5A5A5AB;
         wr(8'h90, v);
         @(posedge clk_i);
         #1 chk(next_desc_o, v[31:4], "next");
         chk({dir_to_pci_o, last_desc_o, desc_in_pci_o}, {v[3], v[1:0]}, "ptrbits");
         rd(8'h90, v);
      end
      wr(8'h94, 32'hFFFFFFFF);
      rd(8'h94, 32'h0001FFFF);
      for (i = 0; i < 4; i = i + 1)
      begin
         wr(8'h94, 32'h40 | i);
         @(posedge clk_i);
         #1 chk(bus_bytes_o, i > 1 ? 3 : i, "width");
      end
      chk(last_desc_o, 1'b1, "blocklst");
      $display("test fields done");
      wr(8'h94, 32'h2043);
      for (i = 0; i < 4; i = i + 1)
      begin
         @(posedge clk_i);
         cache_line_size_setting_i <= 8'h04 << i;
         repeat (2) @(posedge clk_i);
         #1 chk(use_mwi_o, i == 1 || i == 2, "mwi");
      end
      $display("test invalidate done");
      start_x(32'h443, 32'h4);
      watch(2, 4, 3'h3);
      @(posedge clk_i);
      slow_on <= 1'b1;
      personality_i <= 2'h2;
      start_x(32'h840, 32'h0);
      watch(8, 0, 3'h0);
      @(posedge clk_i);
      slow_on <= 1'b0;
      personality_i <= 2'h0;
      rdy_on <= 1'b0;
      start_x(32'h3, 32'h0);
      watch(2, 4, 3'h0);
      start_x(32'h10603, 32'h0);
      watch(2, 4, 3'h6);
      eot_on <= 1'b1;
      start_x(32'h8000, 32'h0);
      watch(8, 1, 3'h0);
      start_x(32'hC000, 32'h0);
      watch(0, 1, 3'h0);
      eot_on <= 1'b0;
      $display("test transfer done");
      rdy_on <= 1'b1;
      req_on <= 1'b0;
      quiet = 1'b0;
      start_x(32'h1041, 32'h0);
      repeat (30)
      begin
         @(posedge clk_i);
         #1 quiet = quiet | local_strobe_o | !chan1_transfer_ack_o;
      end
      chk(quiet, 1'b0, "quiet");
      @(posedge clk_i);
      req_on <= 1'b1;
      ack_exp = 1'b0;
      watch(4, 2, 3'h0);
      $display("test demand done");
      test_done;
   end
endmodule // dmc_top_tb_top
